/* File: common/mcgd_pkg.sv */
// constants for the clock generation and divider block
// assumes a 100 MHz system clock and a single AHB-Lite slave port
package mcgd_pkg;

  // register byte offsets, decoded on the low address bits
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_DIVIDE = 8'h00;
  localparam logic [7:0] ADDR_AUX1 = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // field positions and widths
  localparam int DIV_W = 8;
  localparam int TRIM_W = 6;
  localparam int AUX1_LOWPWR_BIT = 7;
  localparam int TRIM_CLKOUT_BIT = 6;
  localparam int CTRL_PDOWN_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_SETTLE_BIT = 1;
  localparam int STAT_OSC_LSB = 2;
  localparam int STAT_CLKOUT_BIT = 5;

  // reset values
  localparam logic [7:0] DIVIDE_RST = 8'h00;

  // flash configuration codes for the root oscillator
  localparam logic [2:0] OSC_XTAL_LOW = 3'h0;
  localparam logic [2:0] OSC_XTAL_MED = 3'h1;
  localparam logic [2:0] OSC_XTAL_HIGH = 3'h2;
  localparam logic [2:0] OSC_RC = 3'h3;
  localparam logic [2:0] OSC_WDT = 3'h4;
  localparam logic [2:0] OSC_EXT = 3'h5;

  // index of each root source in the synchroniser bank
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_WDT = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // wake-up timing
  localparam logic [9:0] WAKE_ROOT_XTAL = 10'd992;
  localparam logic [9:0] WAKE_ROOT_OTHER = 10'd224;
  localparam int SETTLE_US = 60;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_WAKE_ROOT,
    ST_SETTLE,
    ST_RUN,
    ST_DOWN
  } mcgd_state_t;

endpackage : mcgd_pkg

/* File: src/mcgd_divider.sv */
// programmable divider from root clock ticks to core clock ticks
// assumes root_tick is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
`default_nettype none
module mcgd_divider #(
  parameter int DIV_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic root_tick,
  input wire logic [DIV_W-1:0] div_value,
  output logic div_tick
);

  logic [DIV_W:0] count;
  wire bypass = (div_value == '0);
  wire [DIV_W:0] last = {div_value, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
  // >= lets a smaller divide value take effect mid-period
  wire wrap = bypass || (count >= last);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= root_tick & wrap;
      if (root_tick) begin
        count <= wrap ? '0 : count + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_div_bypass: assert property (
    bypass && root_tick |=> div_tick
  ) else $error("divide value zero did not pass root tick");

  chk_div_wrap_point: assert property (
    root_tick && !bypass && count == last |=> div_tick && count == '0
  ) else $error("divider did not wrap at twice the divide value");

  chk_div_no_early: assert property (
    !bypass && $stable(div_value) && root_tick && count < last
    |=> !div_tick
  ) else $error("divider ticked before its terminal count");

endmodule : mcgd_divider
`default_nettype wire

/* File: src/mcgd_clock_gen.sv */
// clock source selection, wake-up timing and core clock divider
// assumes oscillator outputs and pins are slow against clk_sys
// Summary of operation
// - a machine cycle spans exactly two core clock ticks.
// - peripheral clock tick runs at half the core clock rate.
// - root clock is one of four sources, fed to the divider.
// - source comes from flash configuration bits, never register writes.
// - crystal source holds core clock 992 root ticks plus settling.
// - other sources hold core clock 224 root ticks plus settling.
// - root clock divides by up to 510 under the divide register.
// - divide value may change anytime without stopping the core clock.
// - every reset clears the low-power clock bit.
// - clock out pin driven only if enabled and crystal unused.
// - clock out pin toggles on every core clock tick, so it runs at half the core rate.
// - six-bit trim tunes the rc oscillator, writable by software.
// - trim loads its factory value on power-on reset only.
// - internal rc oscillator is a selectable root source.
// - watchdog oscillator is a selectable root source too.
// - external clock from 0 Hz up; crystal output pin stays free.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mcgd_clock_gen #(
  parameter int SETTLE_CYCLES = mcgd_pkg::SETTLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic por_event,
  input wire logic [2:0] cfg_osc_select,
  input wire logic [mcgd_pkg::TRIM_W-1:0] factory_trim,
  input wire logic rc_osc_clk,
  input wire logic wdt_osc_clk,
  input wire logic xtal_osc_clk,
  input wire logic crystal_input_pin,
  input wire logic rtc_uses_crystal,
  input wire logic wake_pin,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic cpu_core_clock_tick,
  output logic machine_cycle_tick,
  output logic periph_clock_tick,
  output logic [mcgd_pkg::TRIM_W-1:0] rc_trim,
  output logic low_power_clock_bit,
  output logic rc_osc_enable,
  output logic wdt_osc_enable,
  output logic xtal_amp_enable,
  output logic crystal_output_clock_pin_out,
  output logic crystal_output_clock_pin_oe,
  output logic core_running
);

  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);
  localparam int NSYNC = 6;
  localparam int WAKE_IDX = 5;
  localparam int RTC_IDX = 4;

  function automatic logic osc_is_xtal(input logic [2:0] osc);
    osc_is_xtal = (osc == mcgd_pkg::OSC_XTAL_LOW) ||
      (osc == mcgd_pkg::OSC_XTAL_MED) || (osc == mcgd_pkg::OSC_XTAL_HIGH);
  endfunction : osc_is_xtal

  // two-flop synchronisers; third stage only for edge detection
  wire [NSYNC-1:0] async_in = {wake_pin, rtc_uses_crystal,
    crystal_input_pin, xtal_osc_clk, wdt_osc_clk, rc_osc_clk};
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= async_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  // source choice is caught from flash bits while reset is held
  logic [2:0] osc_sel;
  wire cfg_legal = cfg_osc_select <= mcgd_pkg::OSC_EXT;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_sel <= cfg_legal ? cfg_osc_select : mcgd_pkg::OSC_RC;
    end
  end

  wire sel_xtal = osc_is_xtal(osc_sel);
  wire [1:0] src_idx = sel_xtal ? mcgd_pkg::SRC_XTAL :
    (osc_sel == mcgd_pkg::OSC_WDT) ? mcgd_pkg::SRC_WDT :
    (osc_sel == mcgd_pkg::OSC_EXT) ? mcgd_pkg::SRC_EXT :
    mcgd_pkg::SRC_RC;
  // edge based, so a stopped external clock just stalls the core
  wire root_tick = sync_b[src_idx] & ~sync_c[src_idx];
  wire wake_sync = sync_b[WAKE_IDX];
  wire rtc_xtal = sync_b[RTC_IDX];

  always_ff @(posedge clk_sys) begin
    rc_osc_enable <= !sys_rst && osc_sel == mcgd_pkg::OSC_RC;
    wdt_osc_enable <= !sys_rst && osc_sel == mcgd_pkg::OSC_WDT;
    // amplifier off for external clock leaves the output pin free
    xtal_amp_enable <= !sys_rst && (sel_xtal || rtc_xtal);
  end

  // registers
  logic [mcgd_pkg::DIV_W-1:0] divide_reg;
  logic clkout_enable;
  logic pdown_req;
  logic wr_pend;
  logic [mcgd_pkg::ADDR_W-1:0] wr_addr;
  mcgd_pkg::mcgd_state_t state;
  mcgd_pkg::mcgd_state_t next_state;

  wire addr_phase = hsel & htrans[1] & hready;
  wire [mcgd_pkg::ADDR_W-1:0] a_addr = haddr[mcgd_pkg::ADDR_W-1:0];
  wire wr_divide = wr_pend && wr_addr == mcgd_pkg::ADDR_DIVIDE;
  wire wr_aux1 = wr_pend && wr_addr == mcgd_pkg::ADDR_AUX1;
  wire wr_trim = wr_pend && wr_addr == mcgd_pkg::ADDR_TRIM;
  wire wr_ctrl = wr_pend && wr_addr == mcgd_pkg::ADDR_CTRL;
  wire wake_now = state == mcgd_pkg::ST_DOWN && wake_sync;

  wire [31:0] rd_status = {26'h0, crystal_output_clock_pin_oe, osc_sel,
    state == mcgd_pkg::ST_SETTLE, state == mcgd_pkg::ST_RUN};
  wire [31:0] rd_mux =
    (a_addr == mcgd_pkg::ADDR_DIVIDE) ? {24'h0, divide_reg} :
    (a_addr == mcgd_pkg::ADDR_AUX1) ? {24'h0, low_power_clock_bit, 7'h0} :
    (a_addr == mcgd_pkg::ADDR_TRIM) ? {24'h0, 1'b0, clkout_enable, rc_trim} :
    (a_addr == mcgd_pkg::ADDR_CTRL) ? {31'h0, pdown_req} :
    (a_addr == mcgd_pkg::ADDR_STATUS) ? rd_status : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (addr_phase && !hwrite) ? rd_mux : 32'h0;
      wr_pend <= addr_phase && hwrite;
      wr_addr <= a_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divide_reg <= mcgd_pkg::DIVIDE_RST;
      low_power_clock_bit <= 1'b0;
      pdown_req <= 1'b0;
    end else begin
      if (wr_divide) begin
        divide_reg <= hwdata[mcgd_pkg::DIV_W-1:0];
      end
      if (wr_aux1) begin
        // no speed check: keeping the core at 8 MHz is software's job
        low_power_clock_bit <= hwdata[mcgd_pkg::AUX1_LOWPWR_BIT];
      end
      if (wake_now) begin
        pdown_req <= 1'b0;
      end else if (wr_ctrl) begin
        pdown_req <= hwdata[mcgd_pkg::CTRL_PDOWN_BIT];
      end
    end
  end

  // trim survives every reset but power-on
  always_ff @(posedge clk_sys) begin
    if (por_event) begin
      rc_trim <= factory_trim;
      clkout_enable <= 1'b0;
    end else if (wr_trim) begin
      rc_trim <= hwdata[mcgd_pkg::TRIM_W-1:0];
      clkout_enable <= hwdata[mcgd_pkg::TRIM_CLKOUT_BIT];
    end
  end

  // wake-up timer
  logic [9:0] wake_cnt;
  logic [SETTLE_W-1:0] settle_cnt;
  wire [9:0] wake_target = sel_xtal ? mcgd_pkg::WAKE_ROOT_XTAL :
    mcgd_pkg::WAKE_ROOT_OTHER;
  wire wake_done = root_tick && wake_cnt == wake_target - 10'd1;
  wire settle_done = settle_cnt == SETTLE_LAST;

  always_comb begin
    next_state = state;
    unique case (state)
      mcgd_pkg::ST_WAKE_ROOT: if (wake_done) next_state = mcgd_pkg::ST_SETTLE;
      mcgd_pkg::ST_SETTLE: if (settle_done) next_state = mcgd_pkg::ST_RUN;
      mcgd_pkg::ST_RUN: if (pdown_req) next_state = mcgd_pkg::ST_DOWN;
      mcgd_pkg::ST_DOWN: if (wake_sync) next_state = mcgd_pkg::ST_WAKE_ROOT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= mcgd_pkg::ST_WAKE_ROOT;
      wake_cnt <= '0;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      if (state != mcgd_pkg::ST_WAKE_ROOT) begin
        wake_cnt <= '0;
      end else if (root_tick) begin
        wake_cnt <= wake_cnt + 10'd1;
      end
      settle_cnt <= (state == mcgd_pkg::ST_SETTLE) ?
        settle_cnt + 1'b1 : '0;
    end
  end

  // core clock
  logic div_tick;
  mcgd_divider #(
    .DIV_W(mcgd_pkg::DIV_W)
  ) u_divider (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .root_tick(root_tick),
    .div_value(divide_reg),
    .div_tick(div_tick)
  );

  // divider keeps running while gated so a wake needs no realignment
  wire gated_tick = (state == mcgd_pkg::ST_RUN) && div_tick;
  wire clkout_allow = clkout_enable && !sel_xtal && !rtc_xtal;
  logic phase;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpu_core_clock_tick <= 1'b0;
      machine_cycle_tick <= 1'b0;
      periph_clock_tick <= 1'b0;
      phase <= 1'b0;
      core_running <= 1'b0;
      crystal_output_clock_pin_out <= 1'b0;
      crystal_output_clock_pin_oe <= 1'b0;
    end else begin
      cpu_core_clock_tick <= gated_tick;
      machine_cycle_tick <= gated_tick && phase;
      periph_clock_tick <= gated_tick && phase;
      if (gated_tick) begin
        phase <= ~phase;
      end
      core_running <= next_state == mcgd_pkg::ST_RUN;
      crystal_output_clock_pin_oe <= clkout_allow;
      if (!clkout_allow) begin
        crystal_output_clock_pin_out <= 1'b0;
      end else if (gated_tick) begin
        crystal_output_clock_pin_out <= ~crystal_output_clock_pin_out;
      end
    end
  end

  // checks
  logic [1:0] core_since_mc;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || machine_cycle_tick) begin
      core_since_mc <= '0;
    end else if (cpu_core_clock_tick) begin
      core_since_mc <= core_since_mc + 2'd1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_core_gated_off: assert property (
    state != mcgd_pkg::ST_RUN |=> !cpu_core_clock_tick
  ) else $error("core tick while wake-up or power-down holds");

  chk_machine_two_ticks: assert property (
    machine_cycle_tick |-> cpu_core_clock_tick && core_since_mc == 2'd1
  ) else $error("machine cycle not two core ticks");

  chk_pclk_half_rate: assert property (
    periph_clock_tick |-> machine_cycle_tick ##1 !periph_clock_tick
  ) else $error("peripheral tick not at half core rate");

  chk_wake_xtal_count: assert property (
    state == mcgd_pkg::ST_SETTLE && $past(state) == mcgd_pkg::ST_WAKE_ROOT
    && sel_xtal |-> $past(wake_cnt) == mcgd_pkg::WAKE_ROOT_XTAL - 10'd1
  ) else $error("crystal wake-up count wrong");

  chk_wake_other_count: assert property (
    state == mcgd_pkg::ST_SETTLE && $past(state) == mcgd_pkg::ST_WAKE_ROOT
    && !sel_xtal |-> $past(wake_cnt) == mcgd_pkg::WAKE_ROOT_OTHER - 10'd1
  ) else $error("non-crystal wake-up count wrong");

  chk_settle_length: assert property (
    $rose(state == mcgd_pkg::ST_RUN) && $past(state) == mcgd_pkg::ST_SETTLE
    |-> $past(settle_cnt) == SETTLE_LAST
  ) else $error("settling interval wrong length");

  chk_clkout_gate: assert property (
    !clkout_allow |=> !crystal_output_clock_pin_oe
      && !crystal_output_clock_pin_out
  ) else $error("clock out driven while not allowed");

  chk_clkout_toggle: assert property (
    crystal_output_clock_pin_oe && $past(crystal_output_clock_pin_oe)
    && $changed(crystal_output_clock_pin_out) |-> cpu_core_clock_tick
  ) else $error("clock out toggled without a core tick");

  // these watch reset itself, so the default reset gating must not apply
  chk_lowpwr_reset: assert property (
    disable iff (1'b0) sys_rst |=> !low_power_clock_bit
  ) else $error("low-power bit not cleared by reset");

  chk_trim_por_load: assert property (
    disable iff (1'b0) por_event |=> rc_trim == $past(factory_trim)
  ) else $error("trim not loaded on power-on reset");

  chk_trim_hold: assert property (
    disable iff (1'b0) sys_rst && !por_event |=> $stable(rc_trim)
  ) else $error("trim changed on a non power-on reset");

  cov_reach_run: cover property ($rose(core_running));
  cov_machine_cycle: cover property (machine_cycle_tick);
  cov_clkout_toggle: cover property (
    crystal_output_clock_pin_oe && $changed(crystal_output_clock_pin_out));
  cov_pdown_exit: cover property (
    state == mcgd_pkg::ST_DOWN ##1 state == mcgd_pkg::ST_WAKE_ROOT);

endmodule : mcgd_clock_gen
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the clock generation and divider block
// assumes zero wait state register bus and free running source clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic por_event = 1'b1;
  logic rtc_uses_crystal = 1'b0;
  logic wake_pin = 1'b0;
  logic rc = 1'b0, wdt = 1'b0, xtal = 1'b0, ext = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [2:0] cfg_osc_select = 3'h3;
  logic [5:0] factory_trim = 6'h15;
  wire logic hready;
  logic hreadyout, hresp, core_tick, mc_tick, pc_tick, lp, running;
  logic rc_en, wdt_en, amp_en, pin_out, pin_oe;
  logic [31:0] hrdata;
  logic [5:0] rc_trim;
  int miscompares = 0;
  int checks_done = 0;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  mcgd_clock_gen #(.SETTLE_CYCLES(20)) u_mcgd_clock_gen (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .por_event(por_event),
    .cfg_osc_select(cfg_osc_select), .factory_trim(factory_trim),
    .rc_osc_clk(rc), .wdt_osc_clk(wdt), .xtal_osc_clk(xtal),
    .crystal_input_pin(ext), .rtc_uses_crystal(rtc_uses_crystal),
    .wake_pin(wake_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cpu_core_clock_tick(core_tick), .machine_cycle_tick(mc_tick),
    .periph_clock_tick(pc_tick), .rc_trim(rc_trim),
    .low_power_clock_bit(lp), .rc_osc_enable(rc_en),
    .wdt_osc_enable(wdt_en), .xtal_amp_enable(amp_en),
    .crystal_output_clock_pin_out(pin_out),
    .crystal_output_clock_pin_oe(pin_oe), .core_running(running)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // root periods: rc and crystal 4, watchdog 6, external 8
  initial begin
    fork
      forever #20 rc = ~rc;
      forever #20 xtal = ~xtal;
      forever #30 wdt = ~wdt;
      forever #40 ext = ~ext;
    join
  end

  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(what, x, e);
  endtask : rd_chk

  task do_reset(input logic [2:0] code, input logic por);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    por_event <= por;
    cfg_osc_select <= code;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    por_event <= 1'b0;
  endtask : do_reset

  task wait_run(output int n);
    n = 0;
    while (running !== 1'b1 && n < 6000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_run

  task tick_gap(output int g);
    int n;
    n = 0;
    while (core_tick !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (core_tick !== 1'b1 && g < 5000);
  endtask : tick_gap

  task t_regs;
    rd_chk("divide rst", mcgd_pkg::ADDR_DIVIDE, 32'h0);
    rd_chk("aux1 rst", mcgd_pkg::ADDR_AUX1, 32'h0);
    rd_chk("trim por", mcgd_pkg::ADDR_TRIM, 32'h15);
    wr(8'h14, 32'hffff_ffff);
    rd_chk("unmapped", 8'h14, 32'h0);
    wr(mcgd_pkg::ADDR_TRIM, 32'h2a);
    // the write lands on the edge the task returns at
    @(posedge clk_sys);
    chk("trim out", {26'h0, rc_trim}, 32'h2a);
    // core held off here, well below the low-power speed limit
    wr(mcgd_pkg::ADDR_AUX1, 32'h80);
    rd_chk("aux1 set", mcgd_pkg::ADDR_AUX1, 32'h80);
    chk("lp set", {31'h0, lp}, 32'h1);
    do_reset(3'h3, 1'b0);
    @(posedge clk_sys);
    chk("lp cleared", {31'h0, lp}, 32'h0);
    chk("trim kept", {26'h0, rc_trim}, 32'h2a);
    do_reset(3'h3, 1'b1);
    @(posedge clk_sys);
    chk("trim reload", {26'h0, rc_trim}, 32'h15);
  endtask : t_regs

  // rc source, root period 4: core period 4 or 8*N cycles
  task t_divide;
    int g;
    logic [7:0] nv [3];
    nv = '{8'h01, 8'h03, 8'hff};
    foreach (nv[i]) begin
      wr(mcgd_pkg::ADDR_DIVIDE, {24'h0, nv[i]});
      tick_gap(g);
      tick_gap(g);
      chk("core gap", g, 8 * nv[i]);
      chk("still running", {31'h0, running}, 32'h1);
    end
    wr(mcgd_pkg::ADDR_DIVIDE, 32'h1);
    tick_gap(g);
    while (mc_tick !== 1'b1) @(posedge clk_sys);
    chk("machine on core", {31'h0, core_tick}, 32'h1);
    chk("periph with machine", {31'h0, pc_tick}, 32'h1);
    g = 0;
    do begin
      @(posedge clk_sys);
      if (core_tick === 1'b1) g++;
      chk("periph eq", {31'h0, pc_tick}, {31'h0, mc_tick});
    end while (mc_tick !== 1'b1 && g < 5);
    chk("core per machine", g, 2);
  endtask : t_divide

  task t_clkout;
    int ticks, flips;
    logic last;
    wr(mcgd_pkg::ADDR_TRIM, 32'h6a);
    repeat (2) @(posedge clk_sys);
    chk("clkout oe", {31'h0, pin_oe}, 32'h1);
    ticks = 0;
    flips = 0;
    last = pin_out;
    while (ticks < 8) begin
      @(posedge clk_sys);
      if (core_tick === 1'b1) ticks++;
      if (pin_out !== last) flips++;
      last = pin_out;
    end
    chk("clkout flips", flips, 8);
    rtc_uses_crystal <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("clkout rtc", {31'h0, pin_oe}, 32'h0);
    rtc_uses_crystal <= 1'b0;
  endtask : t_clkout

  task t_pdown;
    int n;
    wr(mcgd_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk("down", {31'h0, running}, 32'h0);
    n = 0;
    repeat (100) begin
      @(posedge clk_sys);
      if (core_tick === 1'b1) n++;
    end
    chk("no ticks down", n, 0);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wake_pin <= 1'b0;
    wait_run(n);
    chk("wake delay", n > 860 && n < 940, 1);
  endtask : t_pdown

  // every flash code; delay window allows one root period of phase
  task t_sources;
    int n, g, p, t, s;
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0], 1'b0);
      // illegal codes 6 and 7 fall back to the rc source
      s = (c > 5) ? 3 : c;
      p = (s == 4) ? 6 : (s == 5) ? 8 : 4;
      t = (s < 3) ? 992 : 224;
      wait_run(n);
      chk("wake", n >= t * p - p + 20 && n <= t * p + p + 30, 1);
      chk("rc en", {31'h0, rc_en}, {31'h0, s == 3});
      chk("wdt en", {31'h0, wdt_en}, {31'h0, s == 4});
      chk("amp en", {31'h0, amp_en}, {31'h0, s < 3});
      chk("oe by src", {31'h0, pin_oe}, {31'h0, s > 2});
      tick_gap(g);
      tick_gap(g);
      chk("root gap", g, p);
      rd_chk("src", mcgd_pkg::ADDR_STATUS, s * 4 + 1 + 32 * (s > 2));
    end
  endtask : t_sources

  task print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    int n;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    por_event <= 1'b0;
    t_regs;
    wait_run(n);
    t_divide;
    t_clkout;
    t_pdown;
    t_sources;
    print_verdict;
  end

  initial begin
    // scenarios need about 26k cycles; this allows roughly twice that
    #500_000;
    miscompares++;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
